// ---- src/dwt_pkg.sv ----
// package for the digital watchdog timer: offsets, fields, reset values
// assumes a 32-bit AXI4-Lite register port with byte addresses
//
// How it works
// - counter expiry resets the microcontroller
// - software enable sticks until full reset
// - inactive watchdog allows oscillator-halting stop
// - hardware option: always on, stop becomes wait
// - counting resumes after wake from stop
// - control register resets to FE hex
// - writing zero to reset bit resets now
// - period bits map reversed onto counter
// - 64 timeouts, 3072 to 196608 cycles
// - counter bit six falling triggers reset
// - hardware option reads enable as one
// - inactive counter serves as 7-bit timer
package dwt_pkg;

   // register byte addresses
   localparam logic [7:0] DWT_CTRL_OFS = 8'hD8; // counter and control
   localparam logic [7:0] DWT_STAT_OFS = 8'hDC; // sticky event status
   localparam logic [7:0] DWT_CLR_OFS = 8'hE0; // write one to clear
   localparam logic [7:0] DWT_EN_OFS = 8'hE4; // event enables
   localparam int DWT_ADDR_W = 8;

   // control register fields
   localparam int DWT_C_BIT = 0; // activation
   localparam int DWT_SR_BIT = 1; // software reset, counter msb
   localparam logic [7:0] DWT_CTRL_RESET = 8'hFE;

   // counter shape
   localparam int DWT_CNT_W = 7;
   localparam logic [6:0] DWT_CNT_RESET = 7'h7F;
   localparam logic [6:0] DWT_CNT_EXPIRE = 7'h40; // last value with bit 6 high
   localparam int DWT_PRESCALE_CYC = 3072; // clock cycles per count

   // event bits
   localparam int DWT_EV_EXPIRE = 0;
   localparam int DWT_EV_SWRST = 1;
   localparam int DWT_EV_TIMER = 2;
   localparam int DWT_EV_W = 3;

   // bus answers
   localparam logic [1:0] DWT_RESP_OKAY = 2'h0;
   localparam logic [1:0] DWT_RESP_SLVERR = 2'h2;

   // power state of the core as seen by the watchdog
   typedef enum logic [1:0] {PM_RUN, PM_STOP, PM_WAIT} dwt_pm_t;

   // register byte to counter: bit 7 is count lsb, bit 1 is count msb
   function automatic logic [6:0] dwt_reg_to_cnt(input logic [7:0] r);
      logic [6:0] c;
      c = 7'h00;
      for (int i = 0; i < 6; i++) begin
         c[i] = r[7-i];
      end
      c[6] = r[DWT_SR_BIT];
      return c;
   endfunction

   // counter to register byte, activation bit left zero
   function automatic logic [7:0] dwt_cnt_to_reg(input logic [6:0] c);
      logic [7:0] r;
      r = 8'h00;
      for (int i = 0; i < 6; i++) begin
         r[7-i] = c[i];
      end
      r[DWT_SR_BIT] = c[6];
      return r;
   endfunction

endpackage

// ---- src/dwt_ctr_if.sv ----
// carrier between the watchdog control logic and its downcounter
// assumes both ends run on the same clock
`timescale 1ns/10ps
interface dwt_ctr_if;
   logic load; // reload count this cycle
   logic [6:0] load_val; // value to reload
   logic run; // counting allowed
   logic [6:0] count; // present count
   logic fell; // pulse: bit 6 just fell on a count
   modport ctl (output load, output load_val, output run, input count, input fell);
   modport ctr (input load, input load_val, input run, output count, output fell);
endinterface

// ---- src/dwt_counter.sv ----
// 7-bit downcounter with its prescaler
// assumes load and run come from logic on the same clock
`timescale 1ns/10ps
module dwt_counter
   import dwt_pkg::*;
#(
   parameter int unsigned PRESCALE = dwt_pkg::DWT_PRESCALE_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   dwt_ctr_if.ctr bus
);
   import dwt_pkg::*;

   localparam int PW = $clog2(PRESCALE);
   localparam logic [PW-1:0] PRE_MAX = PW'(PRESCALE - 1);

   // a prescaler of one would need a different tick path
   if (PRESCALE < 2) begin : g_bad_prescale
      $error("dwt_counter: PRESCALE must be at least 2");
   end

   logic [PW-1:0] pre_q, pre_d; // prescaler
   logic [6:0] cnt_q, cnt_d; // downcounter
   logic fell_q, fell_d; // bit 6 fall pulse
   wire tick = bus.run & (pre_q == PRE_MAX);

   // count rate: reload restarts the prescaler so periods stay exact
   assign pre_d = bus.load ? '0 : (!bus.run ? pre_q : (tick ? '0 : pre_q + 1'b1));
   // reload beats a count in the same cycle
   assign cnt_d = bus.load ? bus.load_val : (tick ? cnt_q - 7'h01 : cnt_q);
   // bit six falls only on the step from 40 to 3F hex
   assign fell_d = tick & ~bus.load & (cnt_q == DWT_CNT_EXPIRE);

   // counter state, longest period after reset
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pre_q <= '0;
         cnt_q <= DWT_CNT_RESET;
         fell_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         cnt_q <= cnt_d;
         fell_q <= fell_d;
      end
   end

   assign bus.count = cnt_q;
   assign bus.fell = fell_q;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   fall_step_a: assert property (fell_q |-> cnt_q == 7'h3F && $past(cnt_q) == 7'h40)
      else $error("bit 6 fall flagged off the 40 to 3F step");
   tick_wrap_a: assert property (tick && !bus.load |=> pre_q == '0 && cnt_q == $past(cnt_q) - 7'h01)
      else $error("count step not tied to prescaler wrap");
   hold_stop_a: assert property (!bus.run && !bus.load |=> $stable(cnt_q) && $stable(pre_q))
      else $error("counter moved while halted");
endmodule

// ---- src/dwt_top.sv ----
// digital watchdog timer with AXI4-Lite register access
// assumes stop and wake strobes come from the core on core_clk_i and
// that mcu_reset_o drives the system reset, reset_i included
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dwt_top
   import dwt_pkg::*;
#(
   parameter int unsigned PRESCALE = dwt_pkg::DWT_PRESCALE_CYC
) (
   input wire logic core_clk_i,
   input wire logic reset_i,
   // write address channel
   input wire logic [dwt_pkg::DWT_ADDR_W-1:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   // write data channel
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   // write response channel
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // read address channel
   input wire logic [dwt_pkg::DWT_ADDR_W-1:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   // read data channel
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // option strap, high selects hardware activation
   input wire logic hw_option_i,
   // core power strobes
   input wire logic stop_req_i,
   input wire logic wake_i,
   // outputs to the system
   output logic mcu_reset_o,
   output logic osc_stop_o,
   output logic wait_o,
   output logic irq_o
);
   import dwt_pkg::*;

   // elaboration check on the count rate
   if (PRESCALE < 2) begin : g_bad_prescale
      $error("dwt_top: PRESCALE must be at least 2");
   end

   // option strap synchroniser
   logic hw_s1_q; // first stage, read by hw_q only
   logic hw_q; // settled option level

   // write side of the bus
   logic aw_full_q, aw_full_d; // address held
   logic w_full_q, w_full_d; // data held
   logic [DWT_ADDR_W-1:0] wr_addr_q; // held write address
   logic [31:0] wr_data_q; // held write data
   logic [3:0] wr_strb_q; // held byte enables
   logic awready_q, awready_d;
   logic wready_q, wready_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q;

   // read side of the bus
   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   // watchdog state
   logic c_q, c_d; // software activation latch
   logic rst_q, rst_d; // reset pulse to the system
   logic [DWT_EV_W-1:0] stat_q, stat_d; // sticky events
   logic [DWT_EV_W-1:0] en_q, en_d; // event enables
   logic irq_q, irq_d; // interrupt level
   dwt_pm_t pm_q, pm_d; // power state
   logic osc_stop_q, wait_q; // power outputs

   // counter carrier
   dwt_ctr_if ctr_bus ();

   // option pin crosses two flops before use
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         hw_s1_q <= 1'b0;
         hw_q <= 1'b0;
      end else begin
         hw_s1_q <= hw_option_i;
         hw_q <= hw_s1_q;
      end
   end

   // write channel handshakes
   wire aw_hs = s_axi_awvalid_i & awready_q;
   wire w_hs = s_axi_wvalid_i & wready_q;
   // a write fires once both halves are held and no answer is waiting
   wire do_wr = aw_full_q & w_full_q & ~bvalid_q;

   // write address decode, byte 0 carries every register; a write
   // without that lane still answers OKAY but changes nothing
   wire wr_lane0 = wr_strb_q[0];
   wire wr_is_ctrl = (wr_addr_q == DWT_CTRL_OFS);
   wire wr_is_stat = (wr_addr_q == DWT_STAT_OFS);
   wire wr_is_clr = (wr_addr_q == DWT_CLR_OFS);
   wire wr_is_en = (wr_addr_q == DWT_EN_OFS);
   wire wr_hit = wr_is_ctrl | wr_is_stat | wr_is_clr | wr_is_en;
   wire wr_ctrl = do_wr & wr_is_ctrl & wr_lane0;
   wire wr_clr = do_wr & wr_is_clr & wr_lane0;
   wire wr_en = do_wr & wr_is_en & wr_lane0;

   // channel bookkeeping; ready drops while a half is held or answered
   assign aw_full_d = (aw_full_q | aw_hs) & ~do_wr;
   assign w_full_d = (w_full_q | w_hs) & ~do_wr;
   assign bvalid_d = do_wr | (bvalid_q & ~s_axi_bready_i);
   assign awready_d = ~aw_full_d & ~bvalid_d;
   assign wready_d = ~w_full_d & ~bvalid_d;

   // write channel flops
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         aw_full_q <= 1'b0;
         w_full_q <= 1'b0;
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= DWT_RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q <= w_full_d;
         awready_q <= awready_d;
         wready_q <= wready_d;
         bvalid_q <= bvalid_d;
         // response code held steady while bvalid stands
         if (do_wr) begin
            bresp_q <= wr_hit ? DWT_RESP_OKAY : DWT_RESP_SLVERR;
         end
      end
   end

   // held payloads need no reset
   always_ff @(posedge core_clk_i) begin
      if (aw_hs) begin
         wr_addr_q <= s_axi_awaddr_i;
      end
      if (w_hs) begin
         wr_data_q <= s_axi_wdata_i;
         wr_strb_q <= s_axi_wstrb_i;
      end
   end

   // activation: the option or the latched software bit
   wire active = c_q | hw_q;

   // software enable can only be set, reset alone clears it
   // under the hardware option the write is ignored
   assign c_d = c_q | (wr_ctrl & wr_data_q[DWT_C_BIT] & ~hw_q);

   // software reload of the counter, reversed bit order
   assign ctr_bus.load = wr_ctrl;
   // six period bits pick one of 64 lengths
   // the software reset bit rides along as counter bit six
   assign ctr_bus.load_val = dwt_reg_to_cnt(wr_data_q[7:0]);
   // counting halts only with the oscillator, resumes on wake
   assign ctr_bus.run = (pm_q != PM_STOP);

   // zero in the reset bit resets at once, active or not
   wire sw_rst = wr_ctrl & ~wr_data_q[DWT_SR_BIT];
   // expiry of an active counter resets the microcontroller
   wire expire = active & ctr_bus.fell;
   // inactive, the fall is just a timer event
   wire timer_ev = ~active & ctr_bus.fell;
   assign rst_d = expire | sw_rst;

   // events; a set in the clearing cycle survives
   // so an event is never lost to a clear written at the same time
   wire [DWT_EV_W-1:0] ev_set = {timer_ev, sw_rst, expire};
   wire [DWT_EV_W-1:0] clr_mask = wr_clr ? wr_data_q[DWT_EV_W-1:0] : '0;
   assign stat_d = (stat_q & ~clr_mask) | ev_set;
   assign en_d = wr_en ? wr_data_q[DWT_EV_W-1:0] : en_q;
   assign irq_d = |(stat_d & en_d);

   // watchdog control flops
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         // activation cleared, counter set to its longest period
         c_q <= 1'b0;
         rst_q <= 1'b0;
         stat_q <= '0;
         en_q <= '0;
         irq_q <= 1'b0;
      end else begin
         c_q <= c_d;
         rst_q <= rst_d;
         stat_q <= stat_d;
         en_q <= en_d;
         irq_q <= irq_d;
      end
   end

   // power state: a stop with the watchdog off halts the oscillator,
   // otherwise the core only waits and the counter keeps going
   always_comb begin
      pm_d = pm_q;
      case (pm_q)
         PM_RUN: begin
            if (stop_req_i) begin
               pm_d = active ? PM_WAIT : PM_STOP;
            end
         end
         PM_STOP: begin
            // an interrupt restarts the count where it halted
            if (wake_i) begin
               pm_d = PM_RUN;
            end
         end
         PM_WAIT: begin
            // the countdown runs on through the wait
            if (wake_i) begin
               pm_d = PM_RUN;
            end
         end
         default: begin
            // unused code, fall back to run
            pm_d = PM_RUN;
         end
      endcase
   end

   // power state flops, outputs follow the next state
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         pm_q <= PM_RUN;
         osc_stop_q <= 1'b0;
         wait_q <= 1'b0;
      end else begin
         pm_q <= pm_d;
         osc_stop_q <= (pm_d == PM_STOP);
         wait_q <= (pm_d == PM_WAIT);
      end
   end

   // the downcounter itself
   dwt_counter #(
      .PRESCALE(PRESCALE)
   ) dwt_counter_i (
      .core_clk_i(core_clk_i),
      .reset_i(reset_i),
      .bus(ctr_bus.ctr)
   );

   // read side: an address is answered at the edge that takes it,
   // so the count is read as it stood at that edge
   wire ar_hs = s_axi_arvalid_i & arready_q;
   // activation reads as one under the hardware option
   wire [7:0] ctrl_rd = dwt_cnt_to_reg(ctr_bus.count) | {7'h00, active};
   wire rd_is_ctrl = (s_axi_araddr_i == DWT_CTRL_OFS);
   wire rd_is_stat = (s_axi_araddr_i == DWT_STAT_OFS);
   wire rd_is_clr = (s_axi_araddr_i == DWT_CLR_OFS);
   wire rd_is_en = (s_axi_araddr_i == DWT_EN_OFS);
   wire rd_hit = rd_is_ctrl | rd_is_stat | rd_is_clr | rd_is_en;
   // clear register is write-only and reads zero
   wire [31:0] rd_mux = rd_is_ctrl ? {24'h000000, ctrl_rd} :
                        rd_is_stat ? {29'h00000000, stat_q} :
                        rd_is_en ? {29'h00000000, en_q} : 32'h00000000;
   assign rvalid_d = ar_hs | (rvalid_q & ~s_axi_rready_i);
   assign arready_d = ~rvalid_d;

   // read channel flops
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
      end
   end

   // read data is captured with the address, so it reflects that edge
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         rdata_q <= 32'h00000000;
         rresp_q <= DWT_RESP_OKAY;
      end else if (ar_hs) begin
         rdata_q <= rd_mux;
         rresp_q <= rd_hit ? DWT_RESP_OKAY : DWT_RESP_SLVERR;
      end
   end

   // outputs straight from flops
   assign s_axi_awready_o = awready_q;
   assign s_axi_wready_o = wready_q;
   assign s_axi_bvalid_o = bvalid_q;
   // bresp comes from its own flop, nothing muxed behind the pin
   assign s_axi_bresp_o = bresp_q;
   assign s_axi_arready_o = arready_q;
   assign s_axi_rvalid_o = rvalid_q;
   assign s_axi_rdata_o = rdata_q;
   assign s_axi_rresp_o = rresp_q;
   assign mcu_reset_o = rst_q;
   assign osc_stop_o = osc_stop_q;
   assign wait_o = wait_q;
   assign irq_o = irq_q;

   default clocking @(posedge core_clk_i); endclocking
   default disable iff (reset_i);

   // guards beside the logic, all quiet while reset_i is high
   expiry_reset_a: assert property (active && ctr_bus.fell |=> mcu_reset_o)
      else $error("active expiry gave no reset");
   enable_sticks_a: assert property (c_q |=> c_q)
      else $error("activation dropped without reset");
   stop_allowed_a: assert property (pm_q == PM_RUN && stop_req_i && !active |=> osc_stop_o)
      else $error("inactive stop did not halt oscillator");
   hw_wait_a: assert property (hw_q && pm_q == PM_RUN && stop_req_i |=> wait_o && !osc_stop_o)
      else $error("hardware option stop not turned into wait");
   wake_resume_a: assert property (osc_stop_o && wake_i |=> !osc_stop_o && ctr_bus.run)
      else $error("wake did not resume counting");
   reset_value_a: assert property ($fell(reset_i) |-> ctrl_rd == (hw_q ? 8'hFF : DWT_CTRL_RESET))
      else $error("control register reset value wrong");
   sw_reset_a: assert property (wr_ctrl && !wr_data_q[DWT_SR_BIT] |=> mcu_reset_o ##1 !mcu_reset_o)
      else $error("software reset bit did not pulse reset");
   bit_order_a: assert property (wr_ctrl |=> ctr_bus.count[0] == $past(wr_data_q[7]) && ctr_bus.count[5] == $past(wr_data_q[2]))
      else $error("period bits not reversed onto counter");
   hw_active_a: assert property (hw_q |-> ctrl_rd[DWT_C_BIT] && active)
      else $error("hardware option not reading active");
   free_timer_a: assert property (!active && ctr_bus.fell && !sw_rst |=> !mcu_reset_o && stat_q[DWT_EV_TIMER])
      else $error("inactive timer fall caused reset");
   no_false_reset_a: assert property (!expire && !sw_rst |=> !mcu_reset_o)
      else $error("reset pulse without a cause");
   osc_gated_a: assert property (osc_stop_o |-> !active)
      else $error("oscillator halted while watchdog active");
   sw_status_a: assert property (sw_rst |=> stat_q[DWT_EV_SWRST])
      else $error("software reset not logged in status");
   wait_runs_a: assert property (wait_o |-> ctr_bus.run)
      else $error("counter halted during wait");

   // scenarios the bench should reach
   expire_seen_c: cover property (active ##1 mcu_reset_o);
   stop_seen_c: cover property (osc_stop_o ##[1:20] !osc_stop_o);
   wait_seen_c: cover property (wait_o ##1 ctr_bus.fell);
   irq_seen_c: cover property (irq_o ##1 wr_clr);
   swrst_seen_c: cover property (sw_rst ##1 mcu_reset_o);
endmodule

// ---- bench/digital_watchdog_timer_tb_top.sv ----
// self-checking bench for the watchdog: AXI4-Lite register tasks and timed scenarios
// assumes the bench plays the core and the system reset, and that a short
// prescale keeps every period to at most 1024 cycles
`timescale 1ns/10ps
module digital_watchdog_timer_tb_top;
   import dwt_pkg::*;
   localparam int P = 16; // short prescale, all timing is derived from it
   logic core_clk = 1'b0;
   logic reset_i = 1'b1; // held from time zero
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h00000000;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic hw_opt = 1'b0, stop_req = 1'b0, wake = 1'b0; // option strap and core side strobes
   logic [3:0] wstrb = 4'hF; // byte enables of the write channel
   logic awready, wready, bvalid, arready, rvalid, mcu_rst, osc_stop, wait_st, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, rd, v1;
   logic [1:0] rs;
   int cyc = 0, rst_cnt = 0, rst_cyc = 0, b_cyc = 0, r0;
   int miscompares = 0, n_tests = 0;

   // 50 MHz core clock
   always #10 core_clk = ~core_clk;

   // cycle count and reset-pulse log, the pulse lasts one cycle only
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (mcu_rst === 1'b1) begin
         rst_cnt <= rst_cnt + 1;
         rst_cyc <= cyc;
      end
   end

   dwt_top #(.PRESCALE(P)) dwt_top_i (
      .core_clk_i(core_clk), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
      .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .hw_option_i(hw_opt),
      .stop_req_i(stop_req), .wake_i(wake), .mcu_reset_o(mcu_rst),
      .osc_stop_o(osc_stop), .wait_o(wait_st), .irq_o(irq)
   );

   // verdict and end of run
   task automatic test_done();
      $display("checks %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // a wait that ran out counts as a mismatch
   task automatic hang(input string what);
      $display("wrong value %s expected handshake seen timeout", what);
      miscompares++;
      test_done();
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         miscompares++;
      end
   endtask

   // write: address and data offered together, each dropped once taken
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      bit aw_ok, w_ok;
      int n;
      aw_ok = 0;
      w_ok = 0;
      n = 0;
      @(posedge core_clk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         @(posedge core_clk);
         if (!aw_ok && awready === 1'b1) begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready === 1'b1) begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
         n++;
         if (n > 50) hang("write accept");
      end
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (n > 50) hang("write response");
      end while (bvalid !== 1'b1);
      r = bresp;
      b_cyc = cyc; // one edge after the register effect
      bready <= 1'b0;
   endtask

   // read: rready held until rvalid is sampled
   task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready === 1'b1) arvalid <= 1'b0;
         n++;
         if (n > 50) hang("read");
      end while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
   endtask

   // system reset as the reset pulse would give it, then time for the strap sync
   task automatic do_reset();
      @(posedge core_clk);
      reset_i <= 1'b1;
      repeat (6) @(posedge core_clk);
      reset_i <= 1'b0;
      repeat (4) @(posedge core_clk);
   endtask

   task automatic wait_rst(input int start, input int lim);
      int n;
      n = 0;
      while (rst_cnt == start) begin
         @(posedge core_clk);
         n++;
         if (n > lim) hang("reset pulse");
      end
   endtask

   // one-cycle core strobe: 0 stop, 1 wake
   task automatic strobe(input bit w);
      @(posedge core_clk);
      if (w) wake <= 1'b1;
      else stop_req <= 1'b1;
      @(posedge core_clk);
      wake <= 1'b0;
      stop_req <= 1'b0;
      @(posedge core_clk);
   endtask

   // period k, active: reset pulse k+1 counts after the load, plus one cycle through the reset flop
   task automatic expiry(input logic [7:0] val, input int k);
      r0 = rst_cnt;
      axi_wr(DWT_CTRL_OFS, {24'h0, val}, rs);
      wait_rst(r0, 70 * P);
      chk("expiry cycle", 32'(b_cyc + (k + 1) * P + 1), 32'(rst_cyc));
   endtask

   initial begin
      repeat (6) @(posedge core_clk);
      reset_i <= 1'b0;
      repeat (4) @(posedge core_clk);
      // reset values and unmapped places
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("ctrl reset", 32'h000000FE, rd);
      chk("ctrl resp", 32'(DWT_RESP_OKAY), 32'(rs));
      axi_rd(DWT_STAT_OFS, rd, rs);
      chk("status reset", 32'h00000000, rd);
      axi_rd(8'hF0, rd, rs);
      chk("unmapped read", 32'(DWT_RESP_SLVERR), {30'h0, rs});
      chk("unmapped data", 32'h00000000, rd);
      axi_wr(8'hF0, 32'h00000055, rs);
      chk("unmapped write", 32'(DWT_RESP_SLVERR), {30'h0, rs});
      $display("test reset_values finished");
      // reversed period bits and the free timer with its interrupt
      axi_wr(DWT_EN_OFS, 32'h00000004, rs);
      axi_wr(DWT_CTRL_OFS, 32'h00000082, rs); // count 41 hex, inactive
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("ctrl readback", 32'h00000082, rd);
      repeat (P) @(posedge core_clk);
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("one count down", 32'h00000002, rd);
      r0 = rst_cnt;
      for (int n = 0; n < 4 * P && irq !== 1'b1; n++) @(posedge core_clk);
      chk("timer irq", 32'h00000001, {31'h0, irq});
      chk("no reset inactive", 32'(r0), 32'(rst_cnt));
      axi_rd(DWT_STAT_OFS, rd, rs);
      chk("timer status", 32'h00000004, rd);
      axi_wr(DWT_EN_OFS, 32'h00000000, rs);
      chk("irq masked", 32'h00000000, {31'h0, irq});
      axi_wr(DWT_EN_OFS, 32'h00000004, rs);
      chk("irq unmasked", 32'h00000001, {31'h0, irq});
      axi_wr(DWT_STAT_OFS, 32'h00000000, rs);
      axi_rd(DWT_STAT_OFS, rd, rs);
      chk("status read only", 32'h00000004, rd);
      axi_wr(DWT_CLR_OFS, 32'h00000004, rs);
      axi_rd(DWT_STAT_OFS, rd, rs);
      chk("status cleared", 32'h00000000, rd);
      chk("irq cleared", 32'h00000000, {31'h0, irq});
      $display("test timer_irq finished");
      // stop while inactive halts the oscillator, counting resumes on wake
      strobe(0);
      chk("osc stop", 32'h00000001, {31'h0, osc_stop});
      chk("no wait", 32'h00000000, {31'h0, wait_st});
      axi_rd(DWT_CTRL_OFS, v1, rs);
      repeat (3 * P) @(posedge core_clk);
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("frozen count", v1, rd);
      strobe(1);
      chk("osc running", 32'h00000000, {31'h0, osc_stop});
      repeat (3 * P) @(posedge core_clk);
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("count resumed", 32'h00000001, {31'h0, rd !== v1});
      $display("test stop_inactive finished");
      // activation, sticky enable, stop turned into wait
      expiry(8'h03, 0);
      do_reset();
      axi_wr(DWT_CTRL_OFS, 32'h000000C3, rs); // count 43 hex, activate
      r0 = rst_cnt;
      repeat (3 * P) @(posedge core_clk);
      axi_wr(DWT_CTRL_OFS, 32'h000000C2, rs); // reload in time, enable kept
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("enable sticks", 32'h000000C3, rd);
      strobe(0);
      chk("wait entered", 32'h00000001, {31'h0, wait_st});
      chk("osc kept", 32'h00000000, {31'h0, osc_stop});
      wait_rst(r0, 70 * P);
      chk("expiry in wait", 32'(b_cyc + 4 * P + 1), 32'(rst_cyc));
      do_reset();
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("disabled by reset", 32'h000000FE, rd);
      $display("test activation finished");
      // a write without byte lane zero must not reach the reset bit
      r0 = rst_cnt;
      wstrb <= 4'h0;
      axi_wr(DWT_CTRL_OFS, 32'h00000000, rs);
      wstrb <= 4'hF;
      repeat (2) @(posedge core_clk);
      chk("lane off resp", 32'(DWT_RESP_OKAY), {30'h0, rs});
      chk("lane off no reset", 32'(r0), 32'(rst_cnt));
      // clearing the software reset bit
      r0 = rst_cnt;
      axi_wr(DWT_CTRL_OFS, 32'h00000000, rs);
      repeat (2) @(posedge core_clk);
      chk("sw reset count", 32'(r0 + 1), 32'(rst_cnt));
      chk("sw reset cycle", 32'(b_cyc), 32'(rst_cyc));
      axi_rd(DWT_STAT_OFS, rd, rs);
      chk("sw reset status", 32'h00000002, rd);
      do_reset();
      $display("test software_reset finished");
      // hardware option: always active, enable fixed at one
      hw_opt <= 1'b1;
      do_reset();
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("hw ctrl", 32'h000000FF, rd);
      axi_wr(DWT_CTRL_OFS, 32'h000000FE, rs);
      r0 = rst_cnt;
      axi_rd(DWT_CTRL_OFS, rd, rs);
      chk("hw enable fixed", 32'h000000FF, rd);
      strobe(0);
      chk("hw wait", 32'h00000001, {31'h0, wait_st});
      chk("hw osc kept", 32'h00000000, {31'h0, osc_stop});
      wait_rst(r0, 70 * P);
      chk("longest period", 32'(b_cyc + 64 * P + 1), 32'(rst_cyc));
      hw_opt <= 1'b0;
      do_reset();
      $display("test hardware_option finished");
      test_done();
   end
endmodule
